//--- logic/hci_pkg.sv
package hci_pkg;

  // ---------------------------------------------------------------
  // Serial port addressing
  // ---------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR    = 7'h6A;
  localparam logic [7:0] SUB_CTL     = 8'h68;
  localparam logic [7:0] SUB_RD      = 8'h69;
  localparam logic [7:0] SUB_WR      = 8'h6A;
  localparam logic [3:0] ACK_SLOT    = 4'h8;

  // ---------------------------------------------------------------
  // Control word and status word
  // ---------------------------------------------------------------
  localparam int         CTL_RST_BIT = 8;
  localparam int         TASK_W      = 4;
  localparam int         TASK_L2     = 3;
  localparam logic [15:0] CTL_RST_VAL = 16'h0000;
  localparam logic [7:0] IDX_RST     = 8'h01;
  localparam logic [7:0] IDX_STEP    = 8'h02;

  // ---------------------------------------------------------------
  // Firmware command words and internal register space
  // ---------------------------------------------------------------
  localparam logic [3:0] OP_WR       = 4'h1;
  localparam logic [3:0] OP_RD       = 4'h2;
  localparam logic [3:0] OP_ANC      = 4'h3;
  localparam int         REG_AW      = 8;
  localparam int         DATA_W      = 20;
  localparam int         ANC_BYTES   = 18;
  localparam logic [3:0] ANC_WORDS   = 4'h9;
  localparam int         ANC_CTL1    = 15;
  localparam int         CB1_MSB     = (ANC_BYTES - ANC_CTL1) * 8 - 1;

  // ---------------------------------------------------------------
  // Controller registers on the AHB-Lite side
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL      = 8'h00;
  localparam logic [7:0] A_STAT      = 8'h04;
  localparam logic [7:0] A_DIV       = 8'h08;
  localparam int         C_START     = 8;
  localparam int         C_STOP      = 9;
  localparam int         C_READ      = 10;
  localparam int         C_NACK      = 11;
  localparam int         C_INV       = 12;
  localparam logic [15:0] DIV_RST    = 16'h00FA;

  typedef enum logic [2:0] {
    D_IDLE, D_ADDR, D_SUB, D_CTL, D_WR, D_RD, D_IGN
  } hci_dev_st_t;

  typedef enum logic [2:0] {
    C_NONE, C_WD1, C_WD2, C_RD1, C_RD2, C_ANCS, C_ANC
  } hci_cmd_st_t;

  typedef enum logic [1:0] {
    H_IDLE, H_START, H_BIT, H_STOP
  } hci_host_st_t;

endpackage

//--- logic/hci_link_if.sv
interface hci_link_if;
  logic scl_m_oe;
  logic sda_m_oe;
  logic sda_s_oe;
  logic scl;
  logic sda;

  // Open-drain wired AND: any enabled driver pulls the line low.
  assign scl = ~scl_m_oe;
  assign sda = ~(sda_m_oe | sda_s_oe);

  modport dev  (input scl, input sda, output sda_s_oe);
  modport host (input scl, input sda, output scl_m_oe, output sda_m_oe);
endinterface

//--- logic/hci_pin_sync.sv
module hci_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } hci_sync_t;

  hci_sync_t s_r;
  hci_sync_t s_nxt;
  logic [W-1:0] agree;

  // A bit only moves once the second and third stages agree, which
  // also swallows a single-cycle glitch on the wire.
  always_comb
  begin
    s_nxt    = s_r;
    agree    = ~(s_r.s2 ^ s_r.s3);
    s_nxt.s1 = din;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    s_nxt.q  = (s_r.s3 & agree) | (s_r.q & ~agree);
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      s_r <= '1;
    else
      s_r <= s_nxt;
  end

  assign dout = s_r.q;
endmodule

//--- logic/hci_device.sv
// How it works
// - Controller opens with start, address, subaddress
// - Answer address 1101010x; 0x68 selects control
// - 0x69 reads from device; 0x68/0x6A write
// - Bytes continue until the stop condition
// - Sixteen-bit data word, most significant first
// - Reset bit holds core, port stays alive
// - Writing reset bit clear restarts the core
// - Task bits stay until next control word
// - Controller writes reserved bits as zero
// - No task gives default; task 3 layer-2
// - Commands run without stalling the core
// - Values travel as two words, bits 19:16 first
// - 256 registers, two areas of 128
// - Write and read commands move 20 bits
// - Read without command returns status/index
// - Ancillary block: 18 bytes, refreshed periodically
// - Fetch takes offset and count, returns selection
// - Controller reads exactly the requested count
// - Free-to-air: control byte 1 MSB zero
// - Encrypted mode: controller complements data itself
// - Index low byte odd, steps by two
module hci_device
  import hci_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  hci_link_if.dev                   lk,
  input  wire logic [7:0]           dec_status,
  input  wire logic                 anc_strobe,
  input  wire logic [ANC_BYTES*8-1:0] anc_data,
  input  wire logic                 encrypted_mode,
  input  wire logic [REG_AW-1:0]    core_rd_addr,
  output logic      [DATA_W-1:0]    core_rd_data,
  output logic                      core_hold,
  output logic                      core_restart,
  output logic      [TASK_W-1:0]    task_select_bits,
  output logic                      layer2_only,
  output logic                      default_mode
);
  typedef struct packed {
    hci_dev_st_t         st;
    hci_cmd_st_t         cmd;
    logic [3:0]          cnt;
    logic [7:0]          sh;
    logic [7:0]          hib;
    logic                hi_done;
    logic                rd_sel;
    logic                sda_oe;
    logic [15:0]         tx;
    logic [15:0]         ctl;
    logic                restart;
    logic [7:0]          idx;
    logic [ANC_BYTES*8-1:0] anc;
    logic [REG_AW-1:0]   rad;
    logic [3:0]          dhi;
    logic [3:0]          aoff;
    logic [3:0]          acnt;
    logic                scl_q;
    logic                sda_q;
    logic [DATA_W-1:0]   crd;
  } hci_dev_t;

  hci_dev_t          s_r;
  hci_dev_t          s_nxt;
  logic [DATA_W-1:0] mem [2**REG_AW];
  logic [1:0]        pin_f;
  logic              scl_f;
  logic              sda_f;
  logic              rise;
  logic              fall;
  logic              start_c;
  logic              stop_c;
  logic              load;
  logic              we;
  logic [REG_AW-1:0] wa;
  logic [DATA_W-1:0] wd;
  logic [15:0]       word;
  logic [15:0]       rdw;

  hci_pin_sync #(.W(2)) hci_pin_sync_inst (
    .sys_clk (sys_clk),
    .reset   (reset),
    .din     ({lk.scl, lk.sda}),
    .dout    (pin_f)
  );

  assign scl_f = pin_f[1];
  assign sda_f = pin_f[0];

  // ---------------------------------------------------------------
  // Bus framing, byte decode and firmware command engine
  // ---------------------------------------------------------------
  always_comb
  begin
    s_nxt         = s_r;
    we            = 1'b0;
    wa            = s_r.rad;
    wd            = '0;
    load          = 1'b0;
    rdw           = {dec_status, s_r.idx};
    word          = {s_r.hib, s_r.sh};
    s_nxt.scl_q   = scl_f;
    s_nxt.sda_q   = sda_f;
    s_nxt.restart = 1'b0;
    s_nxt.crd     = mem[core_rd_addr];
    rise    = scl_f & ~s_r.scl_q;
    fall    = ~scl_f & s_r.scl_q;
    start_c = scl_f & s_r.scl_q & s_r.sda_q & ~sda_f;
    stop_c  = scl_f & s_r.scl_q & ~s_r.sda_q & sda_f;

    // The core captures a fresh ancillary block at each refresh.
    if (anc_strobe)
    begin
      s_nxt.anc = anc_data;
      if (!encrypted_mode)
        s_nxt.anc[CB1_MSB] = 1'b0;
      s_nxt.idx = s_r.idx + IDX_STEP;
    end

    if (start_c)
    begin
      s_nxt.st     = D_ADDR;
      s_nxt.cnt    = '0;
      s_nxt.sda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      s_nxt.st     = D_IDLE;
      s_nxt.sda_oe = 1'b0;
    end
    else if (rise && s_r.st != D_IDLE)
    begin
      if (s_r.cnt == ACK_SLOT)
      begin
        s_nxt.cnt = '0;
        if (s_r.st == D_RD && sda_f)
          s_nxt.st = D_IGN;
      end
      else
      begin
        s_nxt.cnt = s_r.cnt + 4'h1;
        s_nxt.sh  = {s_r.sh[6:0], sda_f};
        if (s_r.st == D_RD)
          s_nxt.tx = {s_r.tx[14:0], 1'b0};
      end
    end
    else if (fall && s_r.st != D_IDLE)
    begin
      s_nxt.sda_oe = 1'b0;
      if (s_r.cnt == ACK_SLOT)
      begin
        case (s_r.st)
          D_ADDR:
          begin
            if (s_r.sh[7:1] == DEV_ADDR)
            begin
              s_nxt.sda_oe  = 1'b1;
              s_nxt.hi_done = 1'b0;
              if (!s_r.sh[0])
                s_nxt.st = D_SUB;
              else if (s_r.rd_sel)
              begin
                s_nxt.st = D_RD;
                load     = 1'b1;
              end
              else
                s_nxt.st = D_IGN;
            end
            else
              s_nxt.st = D_IGN;
          end
          D_SUB:
          begin
            s_nxt.sda_oe = 1'b1;
            s_nxt.rd_sel = 1'b0;
            case (s_r.sh)
              SUB_CTL: s_nxt.st = D_CTL;
              SUB_WR:  s_nxt.st = D_WR;
              SUB_RD:
              begin
                s_nxt.rd_sel = 1'b1;
                s_nxt.st     = D_IGN;
              end
              default:
              begin
                s_nxt.sda_oe = 1'b0;
                s_nxt.st     = D_IGN;
              end
            endcase
          end
          D_CTL, D_WR:
          begin
            s_nxt.sda_oe  = 1'b1;
            s_nxt.hi_done = ~s_r.hi_done;
            s_nxt.hib     = s_r.sh;
            if (s_r.hi_done && s_r.st == D_CTL)
            begin
              s_nxt.ctl     = word;
              s_nxt.restart = ~word[CTL_RST_BIT];
            end
            else if (s_r.hi_done)
            begin
              // Command words only touch this port's own storage.
              case (s_r.cmd)
                C_WD1:
                begin
                  s_nxt.dhi = word[3:0];
                  s_nxt.cmd = C_WD2;
                end
                C_WD2:
                begin
                  we        = 1'b1;
                  wd        = {s_r.dhi, word};
                  s_nxt.cmd = C_NONE;
                end
                default:
                begin
                  s_nxt.rad  = word[REG_AW-1:0];
                  s_nxt.aoff = word[7:4];
                  s_nxt.acnt = word[3:0];
                  case (word[15:12])
                    OP_WR:   s_nxt.cmd = C_WD1;
                    OP_RD:   s_nxt.cmd = C_RD1;
                    OP_ANC:  s_nxt.cmd = C_ANCS;
                    default: s_nxt.cmd = C_NONE;
                  endcase
                end
              endcase
            end
          end
          D_RD:
          begin
            s_nxt.hi_done = ~s_r.hi_done;
            load          = s_r.hi_done;
          end
          default: s_nxt.sda_oe = 1'b0;
        endcase
      end
      else if (s_r.st == D_RD)
        s_nxt.sda_oe = ~s_r.tx[15];
    end

    // Next word for the controller to read.
    if (load)
    begin
      case (s_r.cmd)
        C_RD1:
        begin
          rdw       = {12'h000, mem[s_r.rad][19:16]};
          s_nxt.cmd = C_RD2;
        end
        C_RD2:
        begin
          rdw       = mem[s_r.rad][15:0];
          s_nxt.cmd = C_NONE;
        end
        C_ANCS:
          s_nxt.cmd = (s_r.acnt == 4'h0) ? C_NONE : C_ANC;
        C_ANC:
        begin
          // Words past the end of the block read as zero.
          rdw = (s_r.aoff < ANC_WORDS) ?
                s_r.anc[ANC_BYTES*8-1-16*int'(s_r.aoff) -: 16] :
                16'h0000;
          s_nxt.aoff = s_r.aoff + 4'h1;
          s_nxt.acnt = s_r.acnt - 4'h1;
          if (s_r.acnt == 4'h1)
            s_nxt.cmd = C_NONE;
        end
        default: s_nxt.cmd = C_NONE;
      endcase
      s_nxt.tx = rdw;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      s_r         <= '0;
      s_r.st      <= D_IDLE;
      s_r.cmd     <= C_NONE;
      s_r.ctl     <= CTL_RST_VAL;
      s_r.idx     <= IDX_RST;
      s_r.scl_q   <= 1'b1;
      s_r.sda_q   <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // The register array has no reset; only write commands define its content.
  always_ff @(posedge sys_clk)
  begin
    if (we)
      mem[wa] <= wd;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign lk.sda_s_oe       = s_r.sda_oe;
  assign core_rd_data      = s_r.crd;
  assign core_hold         = s_r.ctl[CTL_RST_BIT];
  assign core_restart      = s_r.restart;
  assign task_select_bits  = s_r.ctl[TASK_W-1:0];
  assign layer2_only       = s_r.ctl[TASK_L2];
  assign default_mode      = ~|s_r.ctl[TASK_W-1:0];
endmodule

//--- logic/hci_host.sv
module hci_host
  import hci_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  hci_link_if.host         lk,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);
  typedef struct packed {
    hci_host_st_t st;
    logic [1:0]   q;
    logic [15:0]  tc;
    logic [15:0]  div;
    logic [3:0]   cnt;
    logic [7:0]   tx;
    logic [7:0]   rx;
    logic [4:0]   fl;
    logic         got_nack;
    logic         scl_oe;
    logic         sda_oe;
    logic         a_v;
    logic         a_wr;
    logic [7:0]   a_addr;
    logic [31:0]  rdata;
  } hci_host_t;

  hci_host_t  s_r;
  hci_host_t  s_nxt;
  logic [1:0] pin_f;
  logic       tk;
  logic       busy;
  logic       rd;
  logic [7:0] rxo;

  hci_pin_sync #(.W(2)) hci_pin_sync_inst (
    .sys_clk (sys_clk),
    .reset   (reset),
    .din     ({lk.scl, lk.sda}),
    .dout    (pin_f)
  );

  always_comb
  begin
    s_nxt = s_r;
    rd    = s_r.fl[C_READ-8];
    tk    = (s_r.tc == 16'h0000);
    // A control write still in its data phase already counts as busy.
    busy  = (s_r.st != H_IDLE) |
            (s_r.a_v & s_r.a_wr & (s_r.a_addr == A_CTRL));
    // Encrypted service data arrives complemented; undo it here.
    rxo   = s_r.rx ^ {8{s_r.fl[C_INV-8]}};

    // ---------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ---------------------------------------------------------------
    s_nxt.a_v = hsel & htrans[1] & hready;
    if (s_nxt.a_v)
    begin
      s_nxt.a_wr   = hwrite;
      s_nxt.a_addr = haddr[7:0];
      case (haddr[7:0])
        A_STAT:  s_nxt.rdata = {16'h0000, rxo, 6'h00,
                                s_r.got_nack, busy};
        A_DIV:   s_nxt.rdata = {16'h0000, s_r.div};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // ---------------------------------------------------------------
    // Bit engine, four ticks per bit
    // ---------------------------------------------------------------
    if (s_r.st == H_IDLE || tk)
      s_nxt.tc = s_r.div - 16'h0001;
    else
      s_nxt.tc = s_r.tc - 16'h0001;

    if (s_r.st != H_IDLE && tk)
    begin
      s_nxt.q = s_r.q + 2'h1;
      case (s_r.st)
        H_START:
        begin
          case (s_r.q)
            2'h0: s_nxt.sda_oe = 1'b0;
            2'h1: s_nxt.scl_oe = 1'b0;
            2'h2: s_nxt.sda_oe = 1'b1;
            default:
            begin
              s_nxt.scl_oe = 1'b1;
              s_nxt.st     = H_BIT;
              s_nxt.cnt    = 4'h0;
            end
          endcase
        end
        H_BIT:
        begin
          case (s_r.q)
            2'h0:
              if (s_r.cnt == ACK_SLOT)
                s_nxt.sda_oe = rd & ~s_r.fl[C_NACK-8];
              else
                s_nxt.sda_oe = ~rd & ~s_r.tx[7];
            2'h1: s_nxt.scl_oe = 1'b0;
            2'h2:
              if (s_r.cnt == ACK_SLOT)
                s_nxt.got_nack = ~rd & pin_f[0];
              else
                s_nxt.rx = {s_r.rx[6:0], pin_f[0]};
            default:
            begin
              s_nxt.scl_oe = 1'b1;
              s_nxt.tx     = {s_r.tx[6:0], 1'b0};
              s_nxt.cnt    = s_r.cnt + 4'h1;
              if (s_r.cnt == ACK_SLOT)
              begin
                s_nxt.sda_oe = 1'b0;
                s_nxt.st = s_r.fl[C_STOP-8] ? H_STOP : H_IDLE;
              end
            end
          endcase
        end
        H_STOP:
        begin
          case (s_r.q)
            2'h0: s_nxt.sda_oe = 1'b1;
            2'h1: s_nxt.scl_oe = 1'b0;
            2'h2: s_nxt.sda_oe = 1'b0;
            default: s_nxt.st  = H_IDLE;
          endcase
        end
        default: s_nxt.st = H_IDLE;
      endcase
    end

    // Register writes; a byte order while busy is dropped.
    if (s_r.a_v && s_r.a_wr)
    begin
      case (s_r.a_addr)
        A_CTRL:
          if (s_r.st == H_IDLE)
          begin
            s_nxt.tx       = hwdata[7:0];
            s_nxt.fl       = hwdata[C_INV:C_START];
            s_nxt.got_nack = 1'b0;
            s_nxt.q        = 2'h0;
            s_nxt.cnt      = 4'h0;
            s_nxt.st = hwdata[C_START] ? H_START : H_BIT;
          end
        A_DIV:
          s_nxt.div = (hwdata[15:2] == 14'h0000) ? 16'h0004
                                                  : hwdata[15:0];
        default: s_nxt.div = s_r.div;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      s_r     <= '0;
      s_r.st  <= H_IDLE;
      s_r.div <= DIV_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign lk.scl_m_oe = s_r.scl_oe;
  assign lk.sda_m_oe = s_r.sda_oe;
  assign hrdata      = s_r.rdata;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
endmodule

//--- testbench/hci_link_assertions.sv
// --------------------
// Wire-level tracking
// --------------------
module hci_link_assertions
  import hci_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic scl_m_oe,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       scl_r, sda_r, fr_r;
  logic [3:0] bit_r;
  logic [1:0] byt_r;
  logic [7:0] sh_r, adr_r, sub_r;
  wire logic       rise   = scl & ~scl_r;
  wire logic       strt   = scl & scl_r & sda_r & ~sda;
  wire logic       stp    = scl & scl_r & ~sda_r & sda;
  wire logic       slot   = rise & (bit_r == ACK_SLOT);
  wire logic       wr_ok  = adr_r == {DEV_ADDR, 1'b0};
  wire logic       cmd_ok = sub_r inside {SUB_CTL, SUB_RD, SUB_WR};
  wire logic [7:0] nb     = {sh_r[6:0], sda};

  // Line history resets to the idle level so that leaving reset is not
  // mistaken for a clock rise.
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      {scl_r, sda_r, fr_r, bit_r, byt_r, sh_r, adr_r, sub_r} <= {2'h3, 31'h0};
    else
    begin
      scl_r <= scl;
      sda_r <= sda;
      if (strt)
        {bit_r, byt_r, fr_r} <= 7'h01;
      else if (stp)
        fr_r <= 1'b0;
      else if (slot)
        {bit_r, byt_r} <= {4'h0, byt_r + {1'b0, ~&byt_r}};
      else if (rise)
      begin
        bit_r <= bit_r + 4'h1;
        sh_r  <= nb;
        if (bit_r == 4'h7 && byt_r == 2'h0)
          adr_r <= nb;
        if (bit_r == 4'h7 && byt_r == 2'h1 && !adr_r[0])
          sub_r <= nb;
      end
    end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  addr_ack_a: assert property (slot && byt_r == 2'h0 && wr_ok
    |-> sda_s_oe) else $error("Own address not acknowledged.");
  addr_nack_a: assert property (slot && byt_r == 2'h0
    && adr_r[7:1] != DEV_ADDR |-> !sda_s_oe) else $error("Foreign ack.");
  sub_ack_a: assert property (slot && byt_r == 2'h1 && wr_ok
    && cmd_ok |-> sda_s_oe) else $error("Subaddress not acknowledged.");
  sub_nack_a: assert property (slot && byt_r == 2'h1 && !adr_r[0]
    && !cmd_ok |-> !sda_s_oe) else $error("Bad subaddress acknowledged.");
  data_ack_a: assert property (slot && byt_r[1] && wr_ok
    && sub_r != SUB_RD |-> sda_s_oe) else $error("Data byte refused.");
  read_slot_a: assert property (slot && byt_r != 2'h0 && adr_r[0]
    |-> !sda_s_oe) else $error("Device holds master ack slot.");
  host_slot_a: assert property (slot && !adr_r[0]
    |-> !sda_m_oe) else $error("Host drives device ack slot.");
  stable_high_a: assert property (scl && $past(scl)
    |-> $stable(sda_s_oe)) else $error("Device moved data, clock high.");
  idle_free_a: assert property (!fr_r |-> !sda_s_oe)
    else $error("Device drives line outside a frame.");

  cover property (slot && byt_r == 2'h0 && !sda_s_oe);
  cover property (slot && adr_r[0] && byt_r == 2'h2);
  cover property (stp && sub_r == SUB_CTL);
endmodule

//--- testbench/test_host_control_i2c_slave.sv
// --------------------
// Bench for both ends
// --------------------
module test_host_control_i2c_slave
  import hci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [12:0] K_S = 13'h1 << C_START;
  localparam logic [12:0] K_P = 13'h1 << C_STOP;
  localparam logic [12:0] K_R = 13'h1 << C_READ;
  localparam logic [12:0] K_N = 13'h1 << C_NACK;
  localparam logic [12:0] K_W = {5'h0, DEV_ADDR, 1'b0};
  logic         sys_clk, reset, hsel, hwrite, hreadyout, hresp;
  logic [31:0]  haddr, hwdata, hrdata, st, q;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [7:0]   dec_status, core_rd_addr;
  logic         anc_strobe, encrypted_mode, core_hold, core_restart;
  logic         layer2_only, default_mode;
  logic [143:0] anc_data;
  logic [19:0]  core_rd_data;
  logic [3:0]   task_select_bits;
  logic [15:0]  rw [0:3];
  int           fail_count, n_compared, n_restart;

  hci_link_if lk ();
  hci_device hci_device_inst (.sys_clk, .reset, .lk(lk.dev), .dec_status,
    .anc_strobe, .anc_data, .encrypted_mode, .core_rd_addr, .core_rd_data,
    .core_hold, .core_restart, .task_select_bits, .layer2_only,
    .default_mode);
  hci_host hci_host_inst (.sys_clk, .reset, .lk(lk.host), .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp);
  hci_link_assertions hci_link_assertions_inst (.sys_clk, .reset,
    .scl_m_oe(lk.scl_m_oe), .sda_m_oe(lk.sda_m_oe),
    .sda_s_oe(lk.sda_s_oe), .scl(lk.scl), .sda(lk.sda));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
    if (core_restart === 1'b1)
      n_restart++;

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // One byte on the link; STAT is polled until the engine is idle.
  task automatic xfer(input logic [12:0] c);
    ahb(1'b1, A_CTRL, {19'h0, c}, st);
    st = 32'h1;
    for (int i = 0; i < 500 && st[0] !== 1'b0; i++)
      ahb(1'b0, A_STAT, 32'h0, st);
    check(st[0], 1'b0);
  endtask

  task automatic i2c_wr(input logic [7:0] sub, input logic [47:0] w,
                        input int n);
    xfer(K_S | K_W);
    check(st[1], 1'b0);
    xfer({5'h0, sub});
    check(st[1], 1'b0);
    for (int k = 0; k < 2 * n; k++)
    begin
      xfer({5'h0, w[47 - 8 * k -: 8]} | (k == 2 * n - 1 ? K_P : 13'h0));
      check(st[1], 1'b0);
    end
  endtask

  task automatic i2c_rd(input int n, input logic [12:0] f = 13'h0);
    xfer(K_S | K_W);
    xfer({5'h0, SUB_RD});
    xfer(K_S | K_W | 13'h1);
    check(st[1], 1'b0);
    for (int k = 0; k < 2 * n; k++)
    begin
      xfer(K_R | f | (k == 2 * n - 1 ? K_N | K_P : 13'h0));
      rw[k / 2] = {rw[k / 2][7:0], st[15:8]};
    end
  endtask

  task automatic strobe();
    @(posedge sys_clk);
    anc_strobe <= 1'b1;
    @(posedge sys_clk);
    anc_strobe <= 1'b0;
  endtask

  task automatic t_ctl();
    int n;
    i2c_wr(SUB_CTL, {16'h0108, 32'h0}, 1);
    check(core_hold, 1'b1);
    check(default_mode, 1'b0);
    i2c_rd(1);
    check(rw[0], 16'hC301);
    check(task_select_bits, 4'h8);
    check(layer2_only, 1'b1);
    n = n_restart;
    i2c_wr(SUB_CTL, {16'h0001, 32'h0}, 1);
    check(core_hold, 1'b0);
    check(32'(n_restart - n), 32'h1);
    check(task_select_bits, 4'h1);
    i2c_wr(SUB_CTL, 48'h0, 1);
    check(default_mode, 1'b1);
    $display("Control word test done.");
  endtask

  task automatic t_idx();
    dec_status <= 8'h5A;
    strobe();
    i2c_rd(1);
    check(rw[0], 16'h5A03);
    // The host undoes a complemented service byte on its own side.
    i2c_rd(1, 13'h1 << C_INV);
    check(rw[0], 16'hA5FC);
    $display("Status word test done.");
  endtask

  task automatic t_reg();
    logic [7:0]  a;
    logic [19:0] d;
    for (int k = 0; k < 2; k++)
    begin
      a = k ? 8'h85 : 8'h05;
      d = k ? 20'hA5E31 : 20'h17C63;
      i2c_wr(SUB_WR, {OP_WR, 4'h0, a, 12'h0, d[19:16], d[15:0]}, 3);
      i2c_wr(SUB_WR, {OP_RD, 4'h0, a, 32'h0}, 1);
      i2c_rd(2);
      check({rw[0], rw[1]}, {12'h0, d});
      @(posedge sys_clk);
      core_rd_addr <= a;
      repeat (2) @(posedge sys_clk);
      check(core_rd_data, d);
    end
    core_rd_addr <= 8'h05;
    repeat (2) @(posedge sys_clk);
    check(core_rd_data, 20'h17C63);
    $display("Register command test done.");
  endtask

  task automatic t_anc();
    for (int m = 0; m < 2; m++)
    begin
      encrypted_mode <= m[0];
      strobe();
      i2c_wr(SUB_WR, {OP_ANC, 4'h0, 8'h63, 32'h0}, 1);
      i2c_rd(4);
      check(rw[0], m ? 16'h5A07 : 16'h5A05);
      check(rw[1], 16'h8C8D);
      check(rw[2], {8'h8E, m ? 8'h8F : 8'h0F});
      check(rw[3], 16'h9091);
    end
    $display("Ancillary fetch test done.");
  endtask

  task automatic t_bad();
    xfer(K_S | K_P | {5'h0, DEV_ADDR ^ 7'h01, 1'b0});
    check(st[1], 1'b1);
    xfer(K_S | K_W);
    xfer(K_P | 13'h6B);
    check(st[1], 1'b1);
    i2c_rd(1);
    check(rw[0], 16'h5A07);
    $display("Refusal test done.");
  endtask

  task automatic complete_run();
    $display("Compared %0d, mismatched %0d.", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #900000;
    fail_count++;
    complete_run();
  end

  initial
  begin
    reset = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    dec_status = 8'hC3;
    anc_strobe = 1'b0;
    encrypted_mode = 1'b0;
    core_rd_addr = 8'h00;
    for (int i = 0; i < ANC_BYTES; i++)
      anc_data[143 - 8 * i -: 8] = 8'h80 + 8'(i);
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    ahb(1'b0, A_DIV, 32'h0, q);
    check(q, {16'h0, DIV_RST});
    // The reset divider costs 1000 cycles a bit; 8 keeps the run short.
    ahb(1'b1, A_DIV, 32'h8, q);
    ahb(1'b0, 8'h0C, 32'h0, q);
    check(q, 32'h0);
    t_ctl();
    t_idx();
    t_reg();
    t_anc();
    t_bad();
    complete_run();
  end
endmodule
